// ### design/meh_top.sv
`timescale 1ns/1ps
// What this block does
// RULE_01 - Detect single, double errors; correct single
// RULE_02 - Multi-bit error halts system, never healed
// RULE_03 - Single-bit error redirects address to healer
// RULE_04 - Exactly 32 healer entries per controller
// RULE_05 - All entries used raises healer-full
// RULE_06 - Software retests healed locations after full
// RULE_07 - Software clears entries for reuse
// RULE_08 - Failed 16K blocks mapped out, salvageable
// RULE_09 - Entry holds valid, address, data; hits redirect
module meh_top #(
    parameter int HEAL_N = meh_pkg::HEAL_N   // Healer entries
) (
    input  wire logic                        MCLK_I,         // 200 MHz clock
    input  wire logic                        RSTN_I,         // Async reset, low
    input  wire logic                        CPU_REQ_I,      // Access strobe
    input  wire logic                        CPU_WR_I,       // Write when high
    input  wire logic [meh_pkg::ADDR_W-1:0]  CPU_ADDR_I,     // Word address
    input  wire logic [meh_pkg::DATA_W-1:0]  CPU_WDATA_I,    // Write data
    output logic                             CPU_ACK_O,      // Access done pulse
    output logic      [meh_pkg::DATA_W-1:0]  CPU_RDATA_O,    // Read data
    output logic                             CPU_ERR_O,      // Access refused or double-bit read failed pulse
    output logic                             DBE_HALT_O,     // Double-bit halt level
    output logic      [meh_pkg::ADDR_W-1:0]  DBE_ADDR_O,     // Failing address
    output logic                             HEAL_FULL_O,    // Healer full level
    output logic      [meh_pkg::ADDR_W-1:0]  HEAL_ADDR_O,    // Selected entry address
    output logic                             HEAL_VALID_O,   // Selected entry in use
    input  wire logic [meh_pkg::HEAL_IW-1:0] HEAL_SEL_I,     // Entry to inspect or clear
    input  wire logic                        HEAL_CLR_I,     // Clear selected entry pulse
    input  wire logic                        HEAL_CLR_ALL_I, // Clear all entries pulse
    input  wire logic                        HALT_CLR_I,     // Release halt pulse
    input  wire logic                        BLK_MAP_I,      // Block map write pulse
    input  wire logic [meh_pkg::BLK_W-1:0]   BLK_SEL_I,      // Block number
    input  wire logic                        BLK_OUT_I,      // 1 maps out, 0 salvages
    output logic                             RAM_REQ_O,      // RAM strobe
    output logic                             RAM_WR_O,       // RAM write
    output logic      [meh_pkg::ADDR_W-1:0]  RAM_ADDR_O,     // RAM address
    output logic      [meh_pkg::CODE_W-1:0]  RAM_WCODE_O,    // RAM write code word
    input  wire logic                        RAM_ACK_I,      // RAM done
    input  wire logic [meh_pkg::CODE_W-1:0]  RAM_RCODE_I     // RAM read code word
);
    localparam int IW = meh_pkg::HEAL_IW;   // Entry index width
    localparam int AW = meh_pkg::ADDR_W;    // Word address width
    localparam int DW = meh_pkg::DATA_W;    // Data word width
    localparam int CW = meh_pkg::CODE_W;    // Code word width
    localparam int BW = meh_pkg::BLK_W;     // Block number width
    localparam int BN = meh_pkg::BLK_N;     // Blocks in the map
    localparam int BS = meh_pkg::BLK_SHIFT; // Word address bits inside a block

    // Sequencer
    meh_pkg::meh_state_type   state_reg;              // Current step
    meh_pkg::meh_state_type   state_next;             // Next step
    meh_pkg::meh_cpu_req_type cpu_req;                // Bundled CPU request
    meh_pkg::meh_cpu_req_type hold_reg;               // Request kept during RAM wait
    meh_pkg::meh_cpu_req_type hold_next;              // Next kept request

    // Healer store, one flip-flop entry per index
    meh_pkg::meh_entry_type   entry_reg  [HEAL_N];    // Stored entries
    meh_pkg::meh_entry_type   entry_next [HEAL_N];    // Entries after this cycle
    logic [HEAL_N-1:0]        hit_vec;                // Entry matches address
    logic [HEAL_N-1:0]        free_vec;               // Entry unused
    logic [HEAL_N-1:0]        alloc_vec;              // Lowest free entry, one-hot
    logic [HEAL_N-1:0]        clr_vec;                // Entry cleared by software
    logic [HEAL_N-1:0]        wr_vec;                 // Entry written by CPU hit
    logic [HEAL_N-1:0]        fill_vec;               // Entry filled by a heal
    logic [HEAL_N-1:0]        valid_next;             // Valid flags after this cycle
    logic [DW-1:0]            hit_data;               // Data of the matching entry

    // Block map, one flag per block
    logic [BN-1:0]            blk_out_reg;            // Set where a block is mapped out
    logic [BW-1:0]            req_blk;                // Block of the request

    // Codec
    logic [CW-1:0]            enc_code;               // Code word of write data
    logic [DW-1:0]            dec_data;               // Corrected read data
    logic                     dec_sbe;                // Single-bit error in read
    logic                     dec_dbe;                // Double-bit error in read

    // Decoded events
    logic                     idle_take;              // Request seen while idle
    logic                     refuse;                 // Request refused
    logic                     any_hit;                // Some entry matches
    logic                     hit_take;               // Served by the healer
    logic                     ram_take;               // Sent to RAM
    logic                     ram_done;               // RAM answered
    logic                     rd_done;                // RAM read answered
    logic                     sbe_seen;               // Correctable error
    logic                     dbe_seen;               // Uncorrectable error
    logic                     heal_now;               // A free entry takes the heal

    // Output flip-flops and their next values
    logic                     ack_reg;                // Access done pulse
    logic                     ack_next;               // Next done pulse
    logic                     err_reg;                // Access refused or double-bit read failed pulse
    logic                     err_next;               // Next refused or failed pulse
    logic [DW-1:0]            rdata_reg;              // Read data held
    logic [DW-1:0]            rdata_next;             // Next read data
    logic                     halt_reg;               // Halt level
    logic                     halt_next;              // Next halt level
    logic [AW-1:0]            dbe_addr_reg;           // Last failing address
    logic [AW-1:0]            dbe_addr_next;          // Next failing address
    logic                     full_reg;               // Healer full level
    logic                     full_next;              // Next healer full level
    logic                     sel_valid_reg;          // Selected entry valid
    logic [AW-1:0]            sel_addr_reg;           // Selected entry address
    logic                     ram_req_reg;            // RAM strobe
    logic                     ram_req_next;           // Next RAM strobe
    logic                     ram_wr_reg;             // RAM write
    logic [AW-1:0]            ram_addr_reg;           // RAM address
    logic [CW-1:0]            ram_wcode_reg;          // RAM write code

    // Encoder and checker share one instance; both halves are combinational
    meh_secded codec_u (
        .enc_data_i (CPU_WDATA_I),
        .enc_code_o (enc_code),
        .dec_code_i (RAM_RCODE_I),
        .dec_data_o (dec_data),
        .dec_sbe_o  (dec_sbe),
        .dec_dbe_o  (dec_dbe)
    );

    // Request decode
    assign cpu_req   = {CPU_REQ_I, CPU_WR_I, CPU_ADDR_I, CPU_WDATA_I};
    assign req_blk   = cpu_req.addr[AW-1:BS];
    assign idle_take = (state_reg == meh_pkg::MEH_IDLE) && cpu_req.req;
    // Halted system and mapped-out blocks refuse every access
    assign refuse    = idle_take && (halt_reg || blk_out_reg[req_blk]); // RULE_02 RULE_08
    assign any_hit   = |hit_vec;
    assign hit_take  = idle_take && !refuse && any_hit;                 // RULE_09
    assign ram_take  = idle_take && !refuse && !any_hit;
    assign ram_done  = (state_reg == meh_pkg::MEH_RAM_WAIT) && RAM_ACK_I;
    assign rd_done   = ram_done && !hold_reg.wr;
    assign sbe_seen  = rd_done && dec_sbe;                              // RULE_01
    assign dbe_seen  = rd_done && dec_dbe;                              // RULE_02
    // A full store cannot heal; the word is still corrected on the way out
    assign heal_now  = sbe_seen && (|free_vec);                         // RULE_03

    // Lowest free entry by two's complement, no priority chain
    assign alloc_vec = free_vec & (~free_vec + HEAL_N'(1));

    // Per-entry match, clear, write and fill
    for (genvar g = 0; g < HEAL_N; g++) begin : g_entry
        assign hit_vec[g]  = entry_reg[g].valid && (entry_reg[g].addr == cpu_req.addr); // RULE_09
        assign free_vec[g] = !entry_reg[g].valid;
        assign clr_vec[g]  = HEAL_CLR_ALL_I || (HEAL_CLR_I && (HEAL_SEL_I == IW'(g))); // RULE_07
        assign wr_vec[g]   = hit_take && cpu_req.wr && hit_vec[g];                    // RULE_09
        assign fill_vec[g] = heal_now && alloc_vec[g];                                // RULE_03

        // Fill comes last so a heal wins over a clear in the same cycle
        always_comb begin
            entry_next[g] = entry_reg[g];
            if (clr_vec[g]) begin
                entry_next[g].valid = 1'b0;
            end
            if (wr_vec[g]) begin
                entry_next[g].data = cpu_req.wdata;
            end
            if (fill_vec[g]) begin
                entry_next[g] = {1'b1, hold_reg.addr, dec_data};
            end
        end
        assign valid_next[g] = entry_next[g].valid;

        // Entry storage
        always_ff @(posedge MCLK_I or negedge RSTN_I) begin
            if (!RSTN_I) begin
                entry_reg[g] <= '0;
            end else begin
                entry_reg[g] <= entry_next[g];
            end
        end
    end

    // Merge the matching entry's data; addresses are unique, so OR is safe
    always_comb begin
        hit_data = '0;
        for (int i = 0; i < HEAL_N; i++) begin
            if (hit_vec[i]) begin
                hit_data = hit_data | entry_reg[i].data;
            end
        end
    end

    // Status next values
    assign full_next     = &valid_next;                                 // RULE_04 RULE_05
    assign halt_next     = dbe_seen || (halt_reg && !HALT_CLR_I);       // RULE_02
    assign dbe_addr_next = dbe_seen ? hold_reg.addr : dbe_addr_reg;     // RULE_02
    assign ack_next      = hit_take || (ram_done && !dbe_seen);
    assign err_next      = refuse || dbe_seen;                          // RULE_02
    assign rdata_next    = (hit_take && !cpu_req.wr) ? hit_data :
                           (rd_done && !dec_dbe)     ? dec_data : rdata_reg; // RULE_01
    assign hold_next     = ram_take ? cpu_req : hold_reg;
    assign ram_req_next  = ram_take || (ram_req_reg && !RAM_ACK_I);

    // Step sequence: idle, wait on RAM, one-cycle answer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            meh_pkg::MEH_IDLE: begin
                if (ram_take) begin
                    state_next = meh_pkg::MEH_RAM_WAIT;
                end else if (idle_take) begin
                    state_next = meh_pkg::MEH_DONE;
                end
            end
            meh_pkg::MEH_RAM_WAIT: begin
                if (RAM_ACK_I) begin
                    state_next = meh_pkg::MEH_DONE;
                end
            end
            meh_pkg::MEH_DONE: begin
                state_next = meh_pkg::MEH_IDLE;
            end
            default: begin
                state_next = meh_pkg::MEH_IDLE; // Fourth code is illegal
            end
        endcase
    end

    // Sequencer and kept request
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_reg <= meh_pkg::MEH_IDLE;
            hold_reg  <= '0;
        end else begin
            state_reg <= state_next;
            hold_reg  <= hold_next;
        end
    end

    // CPU answer flip-flops
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg   <= ack_next;
            err_reg   <= err_next;
            rdata_reg <= rdata_next;
        end
    end

    // Halt and healer status; selected entry follows the updated store
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            halt_reg      <= 1'b0;
            dbe_addr_reg  <= '0;
            full_reg      <= 1'b0;
            sel_valid_reg <= 1'b0;
            sel_addr_reg  <= '0;
        end else begin
            halt_reg      <= halt_next;
            dbe_addr_reg  <= dbe_addr_next;
            full_reg      <= full_next;
            sel_valid_reg <= valid_next[HEAL_SEL_I];
            sel_addr_reg  <= entry_next[HEAL_SEL_I].addr;
        end
    end

    // RAM request held until the RAM answers
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ram_req_reg   <= 1'b0;
            ram_wr_reg    <= 1'b0;
            ram_addr_reg  <= '0;
            ram_wcode_reg <= '0;
        end else begin
            ram_req_reg <= ram_req_next;
            if (ram_take) begin
                ram_wr_reg    <= cpu_req.wr;
                ram_addr_reg  <= cpu_req.addr;
                ram_wcode_reg <= enc_code;                            // RULE_01
            end
        end
    end

    // Block map; software salvages by writing a zero
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            blk_out_reg <= '0;
        end else if (BLK_MAP_I) begin
            blk_out_reg[BLK_SEL_I] <= BLK_OUT_I;                     // RULE_08
        end
    end

    // Ports come straight from flip-flops
    assign CPU_ACK_O    = ack_reg;
    assign CPU_ERR_O    = err_reg;
    assign CPU_RDATA_O  = rdata_reg;
    assign DBE_HALT_O   = halt_reg;
    assign DBE_ADDR_O   = dbe_addr_reg;
    assign HEAL_FULL_O  = full_reg;
    assign HEAL_VALID_O = sel_valid_reg;
    assign HEAL_ADDR_O  = sel_addr_reg;
    assign RAM_REQ_O    = ram_req_reg;
    assign RAM_WR_O     = ram_wr_reg;
    assign RAM_ADDR_O   = ram_addr_reg;
    assign RAM_WCODE_O  = ram_wcode_reg;
endmodule

// ### design/meh_pkg.sv
// Shared widths, layouts and states of the memory error healer
package meh_pkg;
    localparam int ADDR_W     = 24;              // Word address width
    localparam int DATA_W     = 32;              // Data word width
    localparam int CHK_W      = 7;               // Hamming check bits for 32 data bits
    localparam int CODE_W     = DATA_W + CHK_W;  // Stored code word width
    localparam int HEAL_N     = 32;              // Healer entries per controller
    localparam int HEAL_IW    = 5;               // Healer index width
    localparam int BLK_BYTES  = 16384;           // Map-out granularity in bytes
    localparam int BLK_SHIFT  = 12;              // 16K bytes of 4-byte words
    localparam int BLK_W      = ADDR_W - BLK_SHIFT; // Block number width
    localparam int BLK_N      = 4096;            // Blocks addressed by BLK_W bits

    // One healer entry
    typedef struct packed {
        logic              valid;  // Entry in use
        logic [ADDR_W-1:0] addr;   // Healed word address
        logic [DATA_W-1:0] data;   // Corrected data word
    } meh_entry_type;

    // A CPU request
    typedef struct packed {
        logic              req;    // Access strobe
        logic              wr;     // Write when set
        logic [ADDR_W-1:0] addr;   // Word address
        logic [DATA_W-1:0] wdata;  // Write data
    } meh_cpu_req_type;

    // Controller sequence
    typedef enum logic [1:0] {
        MEH_IDLE,
        MEH_RAM_WAIT,
        MEH_DONE
    } meh_state_type;
endpackage

// ### design/meh_secded.sv
`timescale 1ns/1ps
// Hamming SECDED encoder and checker for one 32-bit word
module meh_secded (
    input  wire logic [meh_pkg::DATA_W-1:0] enc_data_i,  // Data to encode
    output logic      [meh_pkg::CODE_W-1:0] enc_code_o,  // Code word to store
    input  wire logic [meh_pkg::CODE_W-1:0] dec_code_i,  // Code word read back
    output logic      [meh_pkg::DATA_W-1:0] dec_data_o,  // Corrected data
    output logic                            dec_sbe_o,   // Single-bit error seen
    output logic                            dec_dbe_o    // Double-bit error seen
);
    localparam int PW = meh_pkg::CHK_W - 1; // Positional check bits
    localparam int HW = 38;                 // Hamming positions 1..38

    // Spread data into Hamming positions, skipping powers of two
    function automatic logic [HW:1] spread(input logic [meh_pkg::DATA_W-1:0] d);
        logic [HW:1] h;
        int          k;
        h = '0;
        k = 0;
        for (int p = 1; p <= HW; p++) begin
            if ((p & (p - 1)) != 0) begin
                h[p] = d[k];
                k++;
            end
        end
        return h;
    endfunction

    // Gather data back out of Hamming positions
    function automatic logic [meh_pkg::DATA_W-1:0] gather(input logic [HW:1] h);
        logic [meh_pkg::DATA_W-1:0] d;
        int                         k;
        d = '0;
        k = 0;
        for (int p = 1; p <= HW; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[k] = h[p];
                k++;
            end
        end
        return d;
    endfunction

    // Syndrome over all positions including check positions
    function automatic logic [PW-1:0] syn(input logic [HW:1] h);
        logic [PW-1:0] s;
        s = '0;
        for (int p = 1; p <= HW; p++) begin
            if (h[p]) begin
                s = s ^ PW'(p);
            end
        end
        return s;
    endfunction

    logic [HW:1]   enc_h;   // Encoded positions
    logic [PW-1:0] enc_s;   // Check bits to place
    logic [HW:1]   dec_h;   // Received positions
    logic [PW-1:0] dec_s;   // Received syndrome
    logic [HW:1]   fix_h;   // Corrected positions
    logic          par_err; // Overall parity mismatch

    // Encode: place check bits so the syndrome is zero, then overall parity
    always_comb begin
        enc_h = spread(enc_data_i);
        enc_s = syn(enc_h);
        for (int i = 0; i < PW; i++) begin
            enc_h[1 << i] = enc_s[i];
        end
        enc_code_o = {^enc_h, enc_h};
    end

    // Decode: syndrome points at a flipped bit, parity tells one from two
    always_comb begin
        dec_h   = dec_code_i[HW-1:0];
        dec_s   = syn(dec_h);
        par_err = ^dec_code_i;
        fix_h   = dec_h;
        if (par_err && dec_s != '0 && int'(dec_s) <= HW) begin
            fix_h[dec_s] = ~dec_h[dec_s];
        end
        dec_data_o = gather(fix_h);
        dec_sbe_o  = par_err;                       // RULE_01
        dec_dbe_o  = !par_err && (dec_s != '0);     // RULE_01
    end
endmodule

// ### verif/meh_ram_model.sv
`timescale 1ns/1ps
// RAM array model; flips read bits by mask to make errors
module meh_ram_model (
    input  wire logic                       clk_i,   // Clock
    input  wire logic                       req_i,   // Strobe
    input  wire logic                       wr_i,    // Write
    input  wire logic [meh_pkg::ADDR_W-1:0] addr_i,  // Address
    input  wire logic [meh_pkg::CODE_W-1:0] wcode_i, // Code in
    input  wire logic [meh_pkg::CODE_W-1:0] flip_i,  // Read error mask
    output logic                            ack_o,   // Done
    output logic      [meh_pkg::CODE_W-1:0] rcode_o  // Code out
);
    logic [meh_pkg::CODE_W-1:0] mem [256]; // Low address bits only, aliases above
    initial ack_o = 1'b0;
    initial rcode_o = '0;
    // One-cycle answer; idle data inverted each cycle, so stale code reappears every second cycle
    always @(posedge clk_i) begin
        ack_o <= req_i && !ack_o;
        if (req_i && wr_i) mem[addr_i[7:0]] <= wcode_i;
        rcode_o <= (req_i && !ack_o) ? mem[addr_i[7:0]] ^ flip_i : ~rcode_o;
    end
endmodule

// ### verif/meh_top_props.sv
`timescale 1ns/1ps
// Port checks of the healer
module meh_top_props (
    input wire logic MCLK_I, RSTN_I, CPU_ACK_O, CPU_ERR_O, DBE_HALT_O, HALT_CLR_I,
    input wire logic HEAL_FULL_O, HEAL_CLR_I, HEAL_CLR_ALL_I, HEAL_VALID_O,
    input wire logic RAM_REQ_O, RAM_ACK_I,
    input wire logic [meh_pkg::ADDR_W-1:0] RAM_ADDR_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    chk_ack_err_excl: assert property (!(CPU_ACK_O && CPU_ERR_O)) else $error("ack with err");
    chk_ack_one_pulse: assert property (CPU_ACK_O |=> !CPU_ACK_O) else $error("long ack");
    chk_halt_holds: assert property (DBE_HALT_O && !HALT_CLR_I |=> DBE_HALT_O) else $error("halt lost");
    chk_halt_release: assert property (HALT_CLR_I |=> !DBE_HALT_O) else $error("halt stuck");
    chk_full_holds: assert property (HEAL_FULL_O && !HEAL_CLR_I && !HEAL_CLR_ALL_I |=> HEAL_FULL_O)
        else $error("full lost");
    chk_full_valid: assert property (HEAL_FULL_O |-> HEAL_VALID_O) else $error("full, entry free");
    chk_clr_all_free: assert property (HEAL_CLR_ALL_I |=> !HEAL_FULL_O) else $error("full kept");
    chk_ram_req_hold: assert property (RAM_REQ_O && !RAM_ACK_I |=> RAM_REQ_O && $stable(RAM_ADDR_O))
        else $error("ram request dropped");
endmodule
bind meh_top meh_top_props chk_u (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .CPU_ACK_O(CPU_ACK_O),
    .CPU_ERR_O(CPU_ERR_O), .DBE_HALT_O(DBE_HALT_O), .HALT_CLR_I(HALT_CLR_I),
    .HEAL_FULL_O(HEAL_FULL_O), .HEAL_CLR_I(HEAL_CLR_I), .HEAL_CLR_ALL_I(HEAL_CLR_ALL_I),
    .HEAL_VALID_O(HEAL_VALID_O), .RAM_REQ_O(RAM_REQ_O), .RAM_ACK_I(RAM_ACK_I), .RAM_ADDR_O(RAM_ADDR_O));

// ### verif/memory_error_healer_bench.sv
`timescale 1ns/1ps
// Healer bench: clean, corrected, healed, halted, full and cleared accesses
module memory_error_healer_bench;
    logic MCLK_I = 0, RSTN_I = 0, CPU_REQ_I = 0, CPU_WR_I = 0, HEAL_CLR_ALL_I = 0, HALT_CLR_I = 0;
    logic [23:0] CPU_ADDR_I = '0, DBE_ADDR_O, HEAL_ADDR_O, RAM_ADDR_O;
    logic [31:0] CPU_WDATA_I = '0, CPU_RDATA_O, rd;
    logic [38:0] flip = '0, RAM_WCODE_O, RAM_RCODE_I;
    logic [4:0]  HEAL_SEL_I = '0;
    logic [11:0] BLK_SEL_I = '0;
    logic HEAL_CLR_I = 0, BLK_MAP_I = 0, BLK_OUT_I = 0, ce;
    logic CPU_ACK_O, CPU_ERR_O, DBE_HALT_O, HEAL_FULL_O, HEAL_VALID_O, RAM_REQ_O, RAM_WR_O, RAM_ACK_I;
    int err_count = 0, checks = 0;
    always #2.5 MCLK_I = ~MCLK_I;
    meh_top dut_u (.*);
    meh_ram_model ram_u (.clk_i(MCLK_I), .req_i(RAM_REQ_O), .wr_i(RAM_WR_O), .addr_i(RAM_ADDR_O),
        .wcode_i(RAM_WCODE_O), .flip_i(flip), .ack_o(RAM_ACK_I), .rcode_o(RAM_RCODE_I));
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Request held one edge past the edge that raises ack or err
    task acc(input logic w, input logic [23:0] a, input logic [31:0] d);
        int n;
        n = 0;
        CPU_WR_I <= w; CPU_ADDR_I <= a; CPU_WDATA_I <= d; CPU_REQ_I <= 1'b1;
        do begin @(posedge MCLK_I); #1; n++; end
        while (CPU_ACK_O !== 1'b1 && CPU_ERR_O !== 1'b1 && n < 60);
        if (n >= 60) err_count++;
        rd = CPU_RDATA_O;
        ce = CPU_ERR_O;
        @(posedge MCLK_I);
        CPU_REQ_I <= 1'b0;
        @(posedge MCLK_I);
    endtask
    // One-bit flip corrected, then the heal masks a worse RAM fault
    task t_single;
        acc(1, 24'h00_000A, 32'hA5A5_0001); flip <= 39'h01; acc(0, 24'h00_000A, 0);
        chk(rd, 32'hA5A5_0001);
        flip <= 39'h03; acc(0, 24'h00_000A, 0);
        chk(rd, 32'hA5A5_0001);
        chk(DBE_HALT_O, 0);
        chk(HEAL_ADDR_O, 32'h0000_000A);
        chk(HEAL_VALID_O, 1);
    endtask
    // Two-bit flip halts with the address, then software releases it
    task t_double;
        acc(1, 24'h00_0014, 32'h1234_5678); flip <= 39'h03; acc(0, 24'h00_0014, 0);
        chk(DBE_HALT_O, 1);
        chk(ce, 1);
        chk(DBE_ADDR_O, 32'h0000_0014);
        @(posedge MCLK_I) HALT_CLR_I <= 1; @(posedge MCLK_I) HALT_CLR_I <= 0; flip <= 0;
    endtask
    // 31 more heals fill the store; retest, then clear all
    task t_fill;
        for (int i = 0; i < 31; i++) begin
            if (i == 30) chk(HEAL_FULL_O, 0);
            flip <= 0; acc(1, 24'h00_0020 + i, i); flip <= 39'h01; acc(0, 24'h00_0020 + i, 0);
        end
        chk(HEAL_FULL_O, 1);
        acc(0, 24'h00_000A, 0); flip <= 0;
        chk(rd, 32'hA5A5_0001);
        @(posedge MCLK_I) HEAL_CLR_I <= 1; @(posedge MCLK_I) HEAL_CLR_I <= 0; #1;
        chk(HEAL_VALID_O, 0);
        chk(HEAL_FULL_O, 0);
        @(posedge MCLK_I); acc(0, 24'h00_000A, 0);
        chk(rd, 32'hA5A5_0001);
        HEAL_SEL_I <= 5'd1; HEAL_CLR_ALL_I <= 1; @(posedge MCLK_I) HEAL_CLR_ALL_I <= 0; #1;
        chk(HEAL_FULL_O, 0);
        chk(HEAL_VALID_O, 0);
    endtask
    // Mapped-out block refuses access; salvaged block serves again
    task t_block;
        @(posedge MCLK_I) BLK_OUT_I <= 1; BLK_MAP_I <= 1;
        @(posedge MCLK_I) BLK_MAP_I <= 0; acc(0, 24'h00_000A, 0);
        chk(ce, 1);
        BLK_OUT_I <= 0; BLK_MAP_I <= 1; @(posedge MCLK_I) BLK_MAP_I <= 0;
        acc(0, 24'h00_000A, 0);
        chk(ce, 0);
        chk(rd, 32'hA5A5_0001);
    endtask
    task stop_test;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge MCLK_I);
        RSTN_I <= 1; @(posedge MCLK_I);
        t_single; t_double; t_fill; t_block; stop_test;
    end
    initial begin #100000; err_count++; stop_test; end
endmodule
